// [rtl/mvpc_top.sv]
// Top: APB registers, voltage-code decode, droop, shedding threshold and two channels
// Function
// - Comparator crossing starts one trigger pulse
// - Each trigger fires one phase exactly once
// - Single phase: every trigger to same phase
// - Triggers rotate over n phases in order
// - Channel A droop: 64 codes, 0-3.125 mOhm
// - Channel B droop: 16 codes, 0-0.875 mOhm
// - Code 0 off, 1 is base, step adds
// - Ack all codes, ignore unsupported ones
// - Peak-efficiency field picks threshold base point
// - Offset field adds -2 to 4 A
// - Gate pulses after release until overshoot peak
module mvpc_top (
	input wire logic REF_CLK_IN,
	input wire logic NRST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic CMP_A_IN,
	input wire logic CMP_B_IN,
	input wire logic LOAD_REL_A_IN,
	input wire logic LOAD_REL_B_IN,
	input wire logic OVS_PEAK_A_IN,
	input wire logic OVS_PEAK_B_IN,
	input wire logic [7:0] AVG_CURRENT_A_IN,
	output logic PHASE_ON_TRIGGER_A_OUT,
	output logic PHASE_ON_TRIGGER_B_OUT,
	output logic [5:0] PHASE_ON_A_OUT,
	output logic [2:0] PHASE_ON_B_OUT,
	output logic [11:0] DAC_TARGET_A_OUT,
	output logic [11:0] DAC_TARGET_B_OUT,
	output logic [5:0] DROOP_A_OUT,
	output logic [3:0] DROOP_B_OUT,
	output logic [7:0] SHED_THRESHOLD_OUT,
	output logic [2:0] ACTIVE_PHASES_A_OUT
);
	logic rst_s1;
	logic rst_n;

	// Reset is asserted at once and released through two flops
	always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// Configuration state
	logic [1:0] res_10mv;
	logic [2:0] phases_a;
	logic [1:0] phases_b;
	logic shed_en;
	logic [7:0] vout [mvpc_pkg::NCH];
	logic [11:0] dac [mvpc_pkg::NCH];
	logic [5:0] droop_a;
	logic [3:0] droop_b;
	logic [1:0] shed_peak_eff_reg;
	logic [1:0] shed_offset_reg;
	mvpc_pkg::mvpc_shed_t shed;
	mvpc_pkg::mvpc_shed_t next_shed;
	logic [31:0] rdata;
	logic slverr;

	// APB decode
	wire setup = PSEL_IN & ~PENABLE_IN;
	wire wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
	wire hit_ctrl = (PADDR_IN == mvpc_pkg::ADDR_CTRL);
	wire hit_vout_a = (PADDR_IN == mvpc_pkg::ADDR_VOUT_A);
	wire hit_vout_b = (PADDR_IN == mvpc_pkg::ADDR_VOUT_B);
	wire hit_droop_a = (PADDR_IN == mvpc_pkg::ADDR_DROOP_A);
	wire hit_droop_b = (PADDR_IN == mvpc_pkg::ADDR_DROOP_B);
	wire hit_peak = (PADDR_IN == mvpc_pkg::ADDR_PEAK_EFF);
	wire hit_ofs = (PADDR_IN == mvpc_pkg::ADDR_SHED_OFS);
	wire hit_status = (PADDR_IN == mvpc_pkg::ADDR_STATUS);
	wire hit_dac_a = (PADDR_IN == mvpc_pkg::ADDR_DAC_A);
	wire hit_dac_b = (PADDR_IN == mvpc_pkg::ADDR_DAC_B);
	wire mapped = hit_ctrl | hit_vout_a | hit_vout_b | hit_droop_a | hit_droop_b |
		hit_peak | hit_ofs | hit_status | hit_dac_a | hit_dac_b;

	// Control field extraction from write data
	wire [1:0] wr_res = PWDATA_IN[mvpc_pkg::CTRL_RES_LSB +: 2];
	wire [2:0] wr_pha = PWDATA_IN[mvpc_pkg::CTRL_PHA_LSB +: 3];
	wire [1:0] wr_phb = PWDATA_IN[mvpc_pkg::CTRL_PHB_LSB +: 2];
	wire wr_shed_en = PWDATA_IN[mvpc_pkg::CTRL_SHED_EN_BIT];
	wire [7:0] wr_code = PWDATA_IN[7:0];

	// A phase count of zero or above the channel maximum leaves the old count in place
	wire pha_ok = (wr_pha != 3'h0) && (wr_pha <= 3'(mvpc_pkg::MAXPH_A));
	wire phb_ok = (wr_phb != 2'h0) && (wr_phb <= 2'(mvpc_pkg::MAXPH_B));

	always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			res_10mv <= mvpc_pkg::RST_RES;
			phases_a <= mvpc_pkg::RST_PHA;
			phases_b <= mvpc_pkg::RST_PHB;
			shed_en <= 1'b0;
		end else if (wr && hit_ctrl) begin
			res_10mv <= wr_res;
			shed_en <= wr_shed_en;
			if (pha_ok) begin
				phases_a <= wr_pha;
			end
			if (phb_ok) begin
				phases_b <= wr_phb;
			end
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			droop_a <= mvpc_pkg::RST_DROOP_A;
			droop_b <= mvpc_pkg::RST_DROOP_B;
			shed_peak_eff_reg <= 2'h0;
			shed_offset_reg <= 2'h0;
		end else if (wr) begin
			if (hit_droop_a) begin
				droop_a <= PWDATA_IN[5:0];
			end
			if (hit_droop_b) begin
				droop_b <= PWDATA_IN[3:0];
			end
			if (hit_peak) begin
				shed_peak_eff_reg <= PWDATA_IN[mvpc_pkg::PEAK_EFF_LSB +: 2];
			end
			if (hit_ofs) begin
				shed_offset_reg <= PWDATA_IN[mvpc_pkg::SHED_OFS_LSB +: 2];
			end
		end
	end

	// Per-channel voltage code acceptance and decode
	wire [mvpc_pkg::NCH-1:0] hit_vout = {hit_vout_b, hit_vout_a};

	genvar c;
	generate
		for (c = 0; c < mvpc_pkg::NCH; c++) begin : g_vid
			wire [7:0] max_code = res_10mv[c] ? mvpc_pkg::VID_MAX_10MV :
				mvpc_pkg::VID_MAX_5MV;
			wire supported = (wr_code <= max_code);
			wire [7:0] steps = vout[c] - 8'h01;
			wire [3:0] step = res_10mv[c] ? mvpc_pkg::VID_STEP_10MV :
				mvpc_pkg::VID_STEP_5MV;
			wire [11:0] base = res_10mv[c] ? mvpc_pkg::VID_BASE_10MV :
				mvpc_pkg::VID_BASE_5MV;
			wire [11:0] next_dac = (vout[c] == mvpc_pkg::VID_OFF) ? 12'h000 :
				base + (12'(steps) * 12'(step));

			// Every code write completes without error; unsupported ones change nothing
			always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
				if (!rst_n) begin
					vout[c] <= mvpc_pkg::RST_VOUT;
				end else if (wr && hit_vout[c] && supported) begin
					vout[c] <= wr_code;
				end
			end

			always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
				if (!rst_n) begin
					dac[c] <= 12'h000;
				end else begin
					dac[c] <= next_dac;
				end
			end
		end
	endgenerate

	// Six-to-five shedding threshold and phase drop
	wire [7:0] shed_threshold_six_to_five = mvpc_pkg::SHED_BASE[shed_peak_eff_reg] +
		mvpc_pkg::SHED_OFS[shed_offset_reg];
	wire six_cfg = (phases_a == 3'(mvpc_pkg::MAXPH_A));
	wire below = (AVG_CURRENT_A_IN < shed_threshold_six_to_five);

	// Average current comes from same-clock telemetry, so it is compared directly
	always_comb begin
		next_shed = shed;
		unique case (shed)
			mvpc_pkg::SHED_FULL: begin
				if (shed_en && six_cfg && below) begin
					next_shed = mvpc_pkg::SHED_DROPPED;
				end
			end
			mvpc_pkg::SHED_DROPPED: begin
				if (!shed_en || !six_cfg || !below) begin
					next_shed = mvpc_pkg::SHED_FULL;
				end
			end
		endcase
	end

	always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			shed <= mvpc_pkg::SHED_FULL;
		end else begin
			shed <= next_shed;
		end
	end

	wire [2:0] active_a = (shed == mvpc_pkg::SHED_DROPPED) ? 3'(mvpc_pkg::MAXPH_A - 1) :
		phases_a;

	// Channel instances
	logic hold_a;
	logic hold_b;

	mvpc_chan #(
		.MAXPH(mvpc_pkg::MAXPH_A),
		.PW(mvpc_pkg::PW_A)
	) u_chan_a (
		.clk_in(REF_CLK_IN),
		.rst_n_in(rst_n),
		.cmp_in(CMP_A_IN),
		.load_rel_in(LOAD_REL_A_IN),
		.ovs_peak_in(OVS_PEAK_A_IN),
		.nphase_in(active_a),
		.trigger_out(PHASE_ON_TRIGGER_A_OUT),
		.phase_on_out(PHASE_ON_A_OUT),
		.hold_out(hold_a)
	);

	mvpc_chan #(
		.MAXPH(mvpc_pkg::MAXPH_B),
		.PW(mvpc_pkg::PW_B)
	) u_chan_b (
		.clk_in(REF_CLK_IN),
		.rst_n_in(rst_n),
		.cmp_in(CMP_B_IN),
		.load_rel_in(LOAD_REL_B_IN),
		.ovs_peak_in(OVS_PEAK_B_IN),
		.nphase_in(phases_b),
		.trigger_out(PHASE_ON_TRIGGER_B_OUT),
		.phase_on_out(PHASE_ON_B_OUT),
		.hold_out(hold_b)
	);

	// Read data assembly
	logic [31:0] ctrl_word;
	logic [31:0] status_word;

	always_comb begin
		ctrl_word = mvpc_pkg::APB_ZERO;
		ctrl_word[mvpc_pkg::CTRL_RES_LSB +: 2] = res_10mv;
		ctrl_word[mvpc_pkg::CTRL_PHA_LSB +: 3] = phases_a;
		ctrl_word[mvpc_pkg::CTRL_PHB_LSB +: 2] = phases_b;
		ctrl_word[mvpc_pkg::CTRL_SHED_EN_BIT] = shed_en;
		status_word = mvpc_pkg::APB_ZERO;
		status_word[7:0] = shed_threshold_six_to_five;
		status_word[mvpc_pkg::ST_ACTA_LSB +: 3] = active_a;
		status_word[mvpc_pkg::ST_HOLDA_BIT] = hold_a;
		status_word[mvpc_pkg::ST_HOLDB_BIT] = hold_b;
		status_word[mvpc_pkg::ST_SHED_BIT] = (shed == mvpc_pkg::SHED_DROPPED);
	end

	wire [31:0] sel_rdata =
		hit_ctrl ? ctrl_word :
		hit_vout_a ? {24'h00_0000, vout[0]} :
		hit_vout_b ? {24'h00_0000, vout[1]} :
		hit_droop_a ? {26'h000_0000, droop_a} :
		hit_droop_b ? {28'h000_0000, droop_b} :
		hit_peak ? {30'h0000_0000, shed_peak_eff_reg} :
		hit_ofs ? {16'h0000, shed_offset_reg, 14'h0000} :
		hit_status ? status_word :
		hit_dac_a ? {20'h0_0000, dac[0]} :
		hit_dac_b ? {20'h0_0000, dac[1]} :
		mvpc_pkg::APB_ZERO;

	// Answer is prepared in the setup cycle so read data leaves a flop, zero wait states
	always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= mvpc_pkg::APB_ZERO;
			slverr <= 1'b0;
		end else if (setup) begin
			rdata <= PWRITE_IN ? mvpc_pkg::APB_ZERO : sel_rdata;
			slverr <= ~mapped;
		end
	end

	assign PRDATA_OUT = rdata;
	assign PSLVERR_OUT = slverr & PSEL_IN & PENABLE_IN;
	assign PREADY_OUT = 1'b1;
	assign DAC_TARGET_A_OUT = dac[0];
	assign DAC_TARGET_B_OUT = dac[1];
	assign DROOP_A_OUT = droop_a;
	assign DROOP_B_OUT = droop_b;
	assign SHED_THRESHOLD_OUT = shed_threshold_six_to_five;
	assign ACTIVE_PHASES_A_OUT = active_a;
endmodule : mvpc_top

// [rtl/mvpc_pkg.sv]
// Shared constants and types for the multiphase phase and voltage-code control block
package mvpc_pkg;
	localparam int unsigned NCH = 2;
	localparam int unsigned MAXPH_A = 6;
	localparam int unsigned MAXPH_B = 3;
	localparam int unsigned PW_A = 3;
	localparam int unsigned PW_B = 2;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_VOUT_A = 8'h04;
	localparam logic [7:0] ADDR_VOUT_B = 8'h08;
	localparam logic [7:0] ADDR_DROOP_A = 8'h0C;
	localparam logic [7:0] ADDR_DROOP_B = 8'h10;
	localparam logic [7:0] ADDR_PEAK_EFF = 8'h14;
	localparam logic [7:0] ADDR_SHED_OFS = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;
	localparam logic [7:0] ADDR_DAC_A = 8'h20;
	localparam logic [7:0] ADDR_DAC_B = 8'h24;

	// Control, peak-efficiency, offset and status register fields
	localparam int unsigned CTRL_RES_LSB = 0;
	localparam int unsigned CTRL_PHA_LSB = 2;
	localparam int unsigned CTRL_PHB_LSB = 5;
	localparam int unsigned CTRL_SHED_EN_BIT = 7;
	localparam int unsigned PEAK_EFF_LSB = 0;
	localparam int unsigned SHED_OFS_LSB = 14;
	localparam int unsigned ST_ACTA_LSB = 8;
	localparam int unsigned ST_HOLDA_BIT = 11;
	localparam int unsigned ST_HOLDB_BIT = 12;
	localparam int unsigned ST_SHED_BIT = 13;

	// Reset values
	localparam logic [1:0] RST_RES = 2'h0;
	localparam logic [2:0] RST_PHA = 3'h6;
	localparam logic [1:0] RST_PHB = 2'h2;
	localparam logic [7:0] RST_VOUT = 8'h00;
	localparam logic [5:0] RST_DROOP_A = 6'h00;
	localparam logic [3:0] RST_DROOP_B = 4'h0;

	// Voltage code decode, targets in millivolts
	localparam logic [7:0] VID_OFF = 8'h00;
	localparam logic [11:0] VID_BASE_5MV = 12'h0FA;
	localparam logic [11:0] VID_BASE_10MV = 12'h1F4;
	localparam logic [3:0] VID_STEP_5MV = 4'h5;
	localparam logic [3:0] VID_STEP_10MV = 4'hA;
	localparam logic [7:0] VID_MAX_5MV = 8'hFF;
	localparam logic [7:0] VID_MAX_10MV = 8'hE6;

	// Six-to-five threshold in amps: base includes the -2 A of offset code 00b
	localparam logic [7:0] SHED_BASE [4] = '{8'h3A, 8'h44, 8'h4E, 8'h58};
	localparam logic [7:0] SHED_OFS [4] = '{8'h00, 8'h02, 8'h04, 8'h06};

	localparam logic [31:0] APB_ZERO = 32'h0000_0000;

	typedef enum logic {
		GATE_RUN = 1'b0,
		GATE_HOLD = 1'b1
	} mvpc_gate_t;

	typedef enum logic {
		SHED_FULL = 1'b0,
		SHED_DROPPED = 1'b1
	} mvpc_shed_t;
endpackage : mvpc_pkg

// [rtl/mvpc_chan.sv]
// One channel: comparator trigger, load-release gating and round-robin phase distribution
module mvpc_chan #(
	parameter int unsigned MAXPH = 6,
	parameter int unsigned PW = 3
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic cmp_in,
	input wire logic load_rel_in,
	input wire logic ovs_peak_in,
	input wire logic [PW-1:0] nphase_in,
	output logic trigger_out,
	output logic [MAXPH-1:0] phase_on_out,
	output logic hold_out
);
	logic [2:0] s1;
	logic [2:0] s2;
	logic [2:0] s3;
	logic [PW-1:0] ptr;
	logic [PW-1:0] next_ptr;
	logic [PW-1:0] sel;
	logic [PW-1:0] cur_ptr;
	mvpc_pkg::mvpc_gate_t gate;
	mvpc_pkg::mvpc_gate_t next_gate;
	wire cmp_rise;
	wire rel_rise;
	wire peak_rise;
	wire fire;
	wire ptr_last;

	// Stage one feeds stage two only; edges are taken between stages two and three
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1 <= 3'h0;
			s2 <= 3'h0;
			s3 <= 3'h0;
		end else begin
			s1 <= {ovs_peak_in, load_rel_in, cmp_in};
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign cmp_rise = s2[0] & ~s3[0];
	assign rel_rise = s2[1] & ~s3[1];
	assign peak_rise = s2[2] & ~s3[2];

	// A release seen together with the peak keeps the gate closed
	assign next_gate = rel_rise ? mvpc_pkg::GATE_HOLD :
		(peak_rise ? mvpc_pkg::GATE_RUN : gate);
	assign fire = cmp_rise & (gate == mvpc_pkg::GATE_RUN);

	// A pointer left beyond a shrunken phase count restarts at phase 0 before it is used
	assign cur_ptr = (ptr >= nphase_in) ? PW'(0) : ptr;
	assign ptr_last = (cur_ptr >= nphase_in - PW'(1));
	assign next_ptr = fire ? (ptr_last ? PW'(0) : cur_ptr + PW'(1)) : cur_ptr;
	assign sel = (nphase_in == PW'(1)) ? PW'(0) : cur_ptr;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gate <= mvpc_pkg::GATE_RUN;
			ptr <= PW'(0);
			trigger_out <= 1'b0;
		end else begin
			gate <= next_gate;
			ptr <= next_ptr;
			trigger_out <= fire;
		end
	end

	genvar i;
	generate
		for (i = 0; i < MAXPH; i++) begin : g_phase
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					phase_on_out[i] <= 1'b0;
				end else begin
					phase_on_out[i] <= fire && (sel == PW'(i));
				end
			end
		end
	endgenerate

	assign hold_out = (gate == mvpc_pkg::GATE_HOLD);
endmodule : mvpc_chan

// [tb/mvpc_checker.sv]
// Concurrent checks on the top-level ports of the phase and voltage-code block
module mvpc_checker (
	input wire logic REF_CLK_IN,
	input wire logic NRST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic CMP_A_IN,
	input wire logic PHASE_ON_TRIGGER_A_OUT,
	input wire logic PHASE_ON_TRIGGER_B_OUT,
	input wire logic [5:0] PHASE_ON_A_OUT,
	input wire logic [2:0] PHASE_ON_B_OUT,
	input wire logic [11:0] DAC_TARGET_A_OUT,
	input wire logic [7:0] SHED_THRESHOLD_OUT,
	input wire logic [2:0] ACTIVE_PHASES_A_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!NRST_IN);
	logic [5:0] last_a;
	// Remembers the phase of the previous pulse so the rotation step can be judged
	always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			last_a <= 6'h00;
		end else if (PHASE_ON_TRIGGER_A_OUT) begin
			last_a <= PHASE_ON_A_OUT;
		end
	end
	property p_onehot_a; PHASE_ON_TRIGGER_A_OUT |-> $onehot(PHASE_ON_A_OUT); endproperty
	a_onehot_a: assert property (p_onehot_a) else $error("phase A pulse not one-hot");
	property p_need_trig_a; PHASE_ON_A_OUT != 6'h00 |-> PHASE_ON_TRIGGER_A_OUT; endproperty
	a_need_trig_a: assert property (p_need_trig_a) else $error("phase A pulse w/o trigger");
	property p_pulse_b; PHASE_ON_TRIGGER_B_OUT |-> $onehot(PHASE_ON_B_OUT) ##1 !PHASE_ON_TRIGGER_B_OUT;
	endproperty
	a_pulse_b: assert property (p_pulse_b) else $error("channel B pulse malformed");
	property p_cause_a; $rose(PHASE_ON_TRIGGER_A_OUT) |-> $past(CMP_A_IN, 2); endproperty
	a_cause_a: assert property (p_cause_a) else $error("trigger A without crossing");
	property p_rot_a; PHASE_ON_TRIGGER_A_OUT && last_a != 6'h00
		|-> PHASE_ON_A_OUT == {last_a[4:0], 1'b0} || PHASE_ON_A_OUT == 6'h01; endproperty
	a_rot_a: assert property (p_rot_a) else $error("phase A order broken");
	property p_shed_a; ACTIVE_PHASES_A_OUT == 3'h5 [*2] |-> !PHASE_ON_A_OUT[5]; endproperty
	a_shed_a: assert property (p_shed_a) else $error("shed phase still pulsed");
	property p_thr; SHED_THRESHOLD_OUT >= 8'h3A && SHED_THRESHOLD_OUT <= 8'h5E
		&& !SHED_THRESHOLD_OUT[0]; endproperty
	a_thr: assert property (p_thr) else $error("threshold outside table");
	property p_vout_ack; PSEL_IN && PENABLE_IN && (PADDR_IN == mvpc_pkg::ADDR_VOUT_A
		|| PADDR_IN == mvpc_pkg::ADDR_VOUT_B) |-> PREADY_OUT && !PSLVERR_OUT; endproperty
	a_vout_ack: assert property (p_vout_ack) else $error("voltage code not acked");
	property p_dac_a; DAC_TARGET_A_OUT != 12'h000 |-> DAC_TARGET_A_OUT >= 12'h0FA; endproperty
	a_dac_a: assert property (p_dac_a) else $error("target below first step");
endmodule : mvpc_checker

// [tb/mvpc_stage_model.sv]
// Power-stage side: makes comparator crossings on request and records phase pulses
module mvpc_stage_model #(
	parameter int N = 6
) (
	input wire logic clk_in,
	input wire logic fire_in,
	input wire logic trig_in,
	input wire logic [N-1:0] phase_in,
	output logic cmp_out,
	output logic [N-1:0] last_out,
	output logic [7:0] cnt_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] ctr;
	initial begin
		cmp_out = 1'b0;
		ctr = 4'h0;
		last_out = '0;
		cnt_out = 8'h00;
	end
	// Crossing held high for several cycles, then low long enough to re-arm
	always @(posedge clk_in) begin
		if (fire_in && ctr == 4'h0) begin
			ctr <= 4'hA;
		end else if (ctr != 4'h0) begin
			ctr <= ctr - 4'h1;
		end
		cmp_out <= (fire_in && ctr == 4'h0) || ctr > 4'h4;
		if (trig_in) begin
			last_out <= phase_in;
			cnt_out <= cnt_out + 8'h01;
		end
	end
endmodule : mvpc_stage_model

// [tb/mvpc_top_test.sv]
// Register-level test of the phase and voltage-code block
module mvpc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, psel, pen, pwr, cmp_a, cmp_b, rel_a, rel_b, pk_a, pk_b, fire_a, fire_b;
	logic pready, pslverr, trig_a, trig_b, err, res;
	logic [7:0] paddr, avg, thr, cnt_a, cnt_b, code;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] ph_a, droop_a, last_a;
	logic [2:0] ph_b, act_a, last_b;
	logic [11:0] dac_a, dac_b, exp_mv;
	logic [3:0] droop_b;
	// Codes above 2.5 V assume the host has already raised the loop scale
	logic [7:0] codes [7] = '{8'h01, 8'h2E, 8'hFF, 8'h00, 8'h01, 8'hE6, 8'hE7};
	int fails, cmp_count;
	mvpc_top u_dut (.REF_CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CMP_A_IN(cmp_a), .CMP_B_IN(cmp_b),
		.LOAD_REL_A_IN(rel_a), .LOAD_REL_B_IN(rel_b), .OVS_PEAK_A_IN(pk_a), .OVS_PEAK_B_IN(pk_b),
		.AVG_CURRENT_A_IN(avg), .PHASE_ON_TRIGGER_A_OUT(trig_a), .PHASE_ON_TRIGGER_B_OUT(trig_b),
		.PHASE_ON_A_OUT(ph_a), .PHASE_ON_B_OUT(ph_b), .DAC_TARGET_A_OUT(dac_a),
		.DAC_TARGET_B_OUT(dac_b), .DROOP_A_OUT(droop_a), .DROOP_B_OUT(droop_b),
		.SHED_THRESHOLD_OUT(thr), .ACTIVE_PHASES_A_OUT(act_a));
	mvpc_stage_model #(.N(6)) u_stage_a (.clk_in(clk), .fire_in(fire_a), .trig_in(trig_a),
		.phase_in(ph_a), .cmp_out(cmp_a), .last_out(last_a), .cnt_out(cnt_a));
	mvpc_stage_model #(.N(3)) u_stage_b (.clk_in(clk), .fire_in(fire_b), .trig_in(trig_b),
		.phase_in(ph_b), .cmp_out(cmp_b), .last_out(last_b), .cnt_out(cnt_b));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	// Channel 1 is B; waits long enough for the crossing to pass the synchroniser
	task automatic fire(input logic ch);
		@(posedge clk);
		fire_a <= !ch;
		fire_b <= ch;
		@(posedge clk);
		fire_a <= 1'b0;
		fire_b <= 1'b0;
		repeat (12) @(posedge clk);
		@(negedge clk);
	endtask : fire
	task automatic conclude;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		conclude();
	end
	initial begin
		{psel, pen, pwr, rel_a, rel_b, pk_a, pk_b, fire_a, fire_b, nrst} = 10'h000;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		avg = 8'hFF;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		apb(1'b0, mvpc_pkg::ADDR_CTRL, 32'h0000_0000);
		chk("ctrl reset", rd, 32'h0000_0058);
		// Last code is beyond the 10 mV range, so the previous target must survive
		for (int i = 0; i < 7; i++) begin
			res = i > 3;
			code = codes[i];
			apb(1'b1, mvpc_pkg::ADDR_CTRL, 32'h0000_0058 | res);
			apb(1'b1, mvpc_pkg::ADDR_VOUT_A, {24'h00_0000, code});
			chk("vout error", err, 32'h0000_0000);
			if (!(res && code > mvpc_pkg::VID_MAX_10MV)) exp_mv = code == 8'h00 ? 12'h000 : res ?
				mvpc_pkg::VID_BASE_10MV + (code - 8'h01) * mvpc_pkg::VID_STEP_10MV :
				mvpc_pkg::VID_BASE_5MV + (code - 8'h01) * mvpc_pkg::VID_STEP_5MV;
			repeat (2) @(negedge clk);
			chk("dac a", dac_a, exp_mv);
		end
		apb(1'b1, mvpc_pkg::ADDR_CTRL, 32'h0000_005A);
		apb(1'b1, mvpc_pkg::ADDR_VOUT_B, 32'h0000_0002);
		repeat (2) @(negedge clk);
		chk("dac b", dac_b, mvpc_pkg::VID_BASE_10MV + mvpc_pkg::VID_STEP_10MV);
		chk("dac a 5mv", dac_a, mvpc_pkg::VID_BASE_5MV + 8'hE5 * mvpc_pkg::VID_STEP_5MV);
		apb(1'b0, 8'h28, 32'h0000_0000);
		chk("unmapped error", err, 32'h0000_0001);
		chk("unmapped data", rd, 32'h0000_0000);
		apb(1'b1, mvpc_pkg::ADDR_DROOP_A, 32'h0000_003F);
		apb(1'b1, mvpc_pkg::ADDR_DROOP_B, 32'h0000_000F);
		apb(1'b0, mvpc_pkg::ADDR_DROOP_A, 32'h0000_0000);
		chk("droop a read", rd, 32'h0000_003F);
		@(negedge clk);
		chk("droop a", droop_a, 32'h0000_003F);
		chk("droop b", droop_b, 32'h0000_000F);
		for (int p = 0; p < 4; p++) begin
			for (int o = 0; o < 4; o++) begin
				apb(1'b1, mvpc_pkg::ADDR_PEAK_EFF, 32'(p));
				apb(1'b1, mvpc_pkg::ADDR_SHED_OFS, 32'(o) << 14);
				@(negedge clk);
				chk("threshold", thr, 8'h3A + 8'h0A * p + 8'h02 * o);
			end
		end
		apb(1'b1, mvpc_pkg::ADDR_CTRL, 32'h0000_0058);
		for (int i = 0; i < 7; i++) begin
			fire(1'b0);
			chk("rotation a", last_a, 6'h01 << (i % 6));
			chk("pulse count a", cnt_a, 32'(i + 1));
		end
		for (int i = 0; i < 4; i++) begin
			fire(1'b1);
			chk("rotation b", last_b, 3'h1 << (i % 2));
		end
		apb(1'b1, mvpc_pkg::ADDR_CTRL, 32'h0000_0044);
		for (int i = 0; i < 3; i++) begin
			fire(1'b0);
			chk("single phase", last_a, 32'h0000_0001);
		end
		apb(1'b1, mvpc_pkg::ADDR_CTRL, 32'h0000_0058);
		rel_a <= 1'b1;
		fire(1'b0);
		chk("gated count", cnt_a, 32'h0000_000A);
		apb(1'b0, mvpc_pkg::ADDR_STATUS, 32'h0000_0000);
		chk("hold a set", rd[mvpc_pkg::ST_HOLDA_BIT], 32'h0000_0001);
		pk_a <= 1'b1;
		fire(1'b0);
		chk("resumed count", cnt_a, 32'h0000_000B);
		apb(1'b0, mvpc_pkg::ADDR_STATUS, 32'h0000_0000);
		chk("hold a clear", rd[mvpc_pkg::ST_HOLDA_BIT], 32'h0000_0000);
		rel_a <= 1'b0;
		pk_a <= 1'b0;
		apb(1'b1, mvpc_pkg::ADDR_CTRL, 32'h0000_00D8);
		avg <= 8'h32;
		repeat (4) @(negedge clk);
		chk("shed phases", act_a, 32'h0000_0005);
		for (int i = 0; i < 6; i++) begin
			fire(1'b0);
			chk("shed top phase", last_a[5], 32'h0000_0000);
		end
		@(posedge clk);
		avg <= 8'hFF;
		repeat (4) @(negedge clk);
		chk("full phases", act_a, 32'h0000_0006);
		conclude();
	end
endmodule : mvpc_top_test
bind mvpc_top mvpc_checker u_chk (.REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN), .PSEL_IN(PSEL_IN),
	.PENABLE_IN(PENABLE_IN), .PADDR_IN(PADDR_IN), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .CMP_A_IN(CMP_A_IN), .PHASE_ON_TRIGGER_A_OUT(PHASE_ON_TRIGGER_A_OUT),
	.PHASE_ON_TRIGGER_B_OUT(PHASE_ON_TRIGGER_B_OUT), .PHASE_ON_A_OUT(PHASE_ON_A_OUT),
	.PHASE_ON_B_OUT(PHASE_ON_B_OUT), .DAC_TARGET_A_OUT(DAC_TARGET_A_OUT),
	.SHED_THRESHOLD_OUT(SHED_THRESHOLD_OUT), .ACTIVE_PHASES_A_OUT(ACTIVE_PHASES_A_OUT));
